/* File: rtl/cdhcp_top.sv */
// Host command port of a character display controller: pin capture,
// instruction decode, busy timing, pointer and the two internal RAMs.
// Assumes host pins are asynchronous and a display engine drains the
// write stream; the glyph renderer lives elsewhere.
`timescale 1ns/1ps
module cdhcp_top
  import cdhcp_pkg::*;
#(
  parameter int unsigned CLEAR_CYC = CLEAR_CYC_DEF
) (
  input wire logic ref_clk_i,                   // Core clock, 200 MHz.
  input wire logic rst_i,                       // Synchronous reset.
  input wire logic bus_8080_i,                  // 1: separate strobes.
  input wire logic register_select_i,           // 0 command, 1 data.
  input wire logic enable_or_read_strobe_i,     // E or read strobe low.
  input wire logic direction_or_write_strobe_i, // Read not write, or write low.
  input wire logic [7:0] db_i,                  // Data pins in.
  output logic [7:0] db_o,                      // Data pins out.
  output logic db_oe_o,                         // Drive data pins.
  output logic busy_o,                          // Operation pending flag.
  output logic [6:0] ram_pointer_o,             // RAM pointer.
  output logic display_on_o,                    // Display enabled.
  output logic cursor_on_o,                     // Cursor visible.
  output logic blink_on_o,                      // Cursor blink.
  output logic graphic_mode_o,                  // Graphic mode.
  output logic power_on_o,                      // Power converter on.
  output logic bus_width_8_o,                   // Eight-bit interface.
  output logic two_lines_o,                     // Two display lines.
  output logic tall_font_o,                     // Tall glyphs.
  output logic [1:0] font_table_o,              // Font table select.
  output logic [6:0] display_shift_o,           // Net left shift count.
  output logic wr_valid_o,                      // RAM write stream valid.
  output logic [XFIFO_WIDTH-1:0] wr_data_o,     // {glyph, addr, byte}.
  input wire logic wr_ready_i                   // Stream consumer ready.
);

  // ----------
  // State
  // ----------
  typedef struct packed {
    cdhcp_phase_e phase;
    logic [BUSY_W-1:0] busy_cnt;
    logic busy;
    logic e_prev;
    logic rw_prev;
    logic [6:0] ram_ptr;
    logic sel_glyph;
    logic step_up;
    logic shift_entry;
    logic disp_on;
    logic cursor_on;
    logic blink_on;
    logic graphic;
    logic power_on;
    logic bus8;
    logic two_lines;
    logic tall_font;
    logic [1:0] font_tbl;
    logic [6:0] disp_ofs;
    logic pend_step;
    logic pend_shift;
    logic nib_phase;
    logic [3:0] nib_hi;
    logic [7:0] db_out;
    logic db_oe;
    logic [6:0] clr_idx;
    logic push_v;
    logic [XFIFO_WIDTH-1:0] push_data;
  } cdhcp_state_s;

  cdhcp_state_s s_q;
  cdhcp_state_s s_d;

  logic [7:0] display_ram [DRAM_DEPTH];
  logic [7:0] glyph_ram [GRAM_DEPTH];

  logic [11:0] pins_s;
  logic mode80_s;
  logic rs_s;
  logic e_s;
  logic rw_s;
  logic [7:0] db_s;
  logic fifo_in_ready;

  logic rd_lvl;
  logic rd_end;
  logic wr_end;
  logic byte_done;
  logic [7:0] byte_val;
  logic [7:0] ram_rd;
  logic [7:0] rd_byte;
  logic dram_we;
  logic [6:0] dram_wa;
  logic [7:0] dram_wd;
  logic gram_we;
  logic [5:0] gram_wa;

  // ----------
  // Pin capture
  // ----------
  cdhcp_sync #(
    .W(12)
  ) u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .async_i({bus_8080_i, register_select_i, enable_or_read_strobe_i,
              direction_or_write_strobe_i, db_i}),
    .sync_o(pins_s)
  );

  assign mode80_s = pins_s[11];
  assign rs_s = pins_s[10];
  assign e_s = pins_s[9];
  assign rw_s = pins_s[8];
  assign db_s = pins_s[7:0];

  // The write stream is queued so a slow display engine only stalls the
  // busy flag, never drops a character.
  cdhcp_fifo #(
    .WIDTH(XFIFO_WIDTH),
    .DEPTH(XFIFO_DEPTH)
  ) u_fifo (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .in_valid_i(s_q.push_v),
    .in_ready_o(fifo_in_ready),
    .in_data_i(s_q.push_data),
    .out_valid_o(wr_valid_o),
    .out_ready_i(wr_ready_i),
    .out_data_o(wr_data_o)
  );

  function automatic logic [6:0] step_ptr(input logic [6:0] p, input logic up, input logic glyph);
    logic [6:0] n;
    n = up ? p + 7'h01 : p - 7'h01;
    if (glyph) begin
      n[6] = 1'b0;
    end
    return n;
  endfunction

  // ----------
  // Strobe decoding
  // ----------
  // [RULE24] strobe style select
  always_comb begin
    if (mode80_s) begin
      // An end counts only while the other strobe idles high, so reset release is no edge.
      rd_lvl = ~e_s;
      rd_end = e_s & ~s_q.e_prev & s_q.rw_prev;
      wr_end = rw_s & ~s_q.rw_prev & s_q.e_prev;
    end else begin
      rd_lvl = e_s & rw_s;
      rd_end = ~e_s & s_q.e_prev & s_q.rw_prev;
      wr_end = ~e_s & s_q.e_prev & ~s_q.rw_prev;
    end
  end

  assign ram_rd = s_q.sel_glyph ? glyph_ram[s_q.ram_ptr[5:0]] : display_ram[s_q.ram_ptr];
  // [RULE17] status read layout
  // [RULE19] data read source
  assign rd_byte = rs_s ? ram_rd : {s_q.busy, s_q.ram_ptr};

  // ----------
  // Next state
  // ----------
  always_comb begin
    s_d = s_q;
    byte_done = 1'b0;
    byte_val = db_s;
    dram_we = 1'b0;
    dram_wa = s_q.ram_ptr;
    dram_wd = db_s;
    gram_we = 1'b0;
    gram_wa = s_q.ram_ptr[5:0];

    s_d.e_prev = e_s;
    s_d.rw_prev = rw_s;
    s_d.db_oe = rd_lvl;

    // [RULE25] nibble order on reads
    if (s_q.bus8) begin
      s_d.db_out = rd_byte;
    end else if (!s_q.nib_phase) begin
      s_d.db_out = {rd_byte[7:4], 4'h0};
    end else begin
      s_d.db_out = {rd_byte[3:0], 4'h0};
    end

    // [RULE25] nibble pairing
    if (rd_end || wr_end) begin
      if (s_q.bus8) begin
        byte_done = 1'b1;
      end else if (!s_q.nib_phase) begin
        s_d.nib_phase = 1'b1;
        s_d.nib_hi = db_s[7:4];
      end else begin
        s_d.nib_phase = 1'b0;
        byte_done = 1'b1;
        byte_val = {s_q.nib_hi, db_s[7:4]};
      end
    end

    if (s_q.push_v && fifo_in_ready) begin
      s_d.push_v = 1'b0;
    end

    // Busy sequencing; the clear phase blanks one location per cycle.
    unique case (s_q.phase)
      CDHCP_IDLE: begin
      end
      CDHCP_CLEAR: begin
        // [RULE7] blank every location
        dram_we = 1'b1;
        dram_wa = s_q.clr_idx;
        dram_wd = BLANK_CODE;
        s_d.clr_idx = s_q.clr_idx + 7'h01;
        s_d.busy_cnt = s_q.busy_cnt - 1'b1;
        if (s_q.clr_idx == 7'(DRAM_DEPTH - 1)) begin
          s_d.phase = CDHCP_EXEC;
        end
      end
      CDHCP_EXEC: begin
        if (s_q.busy_cnt != '0) begin
          s_d.busy_cnt = s_q.busy_cnt - 1'b1;
        end else if (!s_q.push_v) begin
          // [RULE3] release busy
          s_d.busy = 1'b0;
          s_d.phase = CDHCP_IDLE;
          s_d.pend_step = 1'b0;
          s_d.pend_shift = 1'b0;
          // [RULE20] late pointer update
          if (s_q.pend_step) begin
            // [RULE21] step direction
            s_d.ram_ptr = step_ptr(s_q.ram_ptr, s_q.step_up, s_q.sel_glyph);
          end
          // [RULE6] entry shift
          if (s_q.pend_shift) begin
            s_d.disp_ofs = s_q.step_up ? s_q.disp_ofs + 7'h01 : s_q.disp_ofs - 7'h01;
          end
        end
      end
    endcase

    // [RULE2] ignore all but status read while busy
    if (byte_done && !s_q.busy && !(rd_end && !rs_s)) begin
      s_d.busy = 1'b1;
      s_d.phase = CDHCP_EXEC;
      s_d.busy_cnt = BUSY_W'(OP_CYC);
      if (rs_s) begin
        // [RULE5] auto step after access
        s_d.pend_step = 1'b1;
        s_d.pend_shift = s_q.shift_entry & ~s_q.sel_glyph;
        if (wr_end) begin
          // [RULE18] store into selected RAM
          dram_we = ~s_q.sel_glyph;
          gram_we = s_q.sel_glyph;
          dram_wd = byte_val;
          s_d.push_v = 1'b1;
          s_d.push_data = {s_q.sel_glyph, s_q.ram_ptr, byte_val};
        end
      end else if (byte_val[7]) begin
        // [RULE16] display address load
        s_d.ram_ptr = byte_val[6:0];
        s_d.sel_glyph = 1'b0;
      end else if (byte_val[6]) begin
        // [RULE15] glyph address load
        s_d.ram_ptr = {1'b0, byte_val[5:0]};
        s_d.sel_glyph = 1'b1;
      end else if (byte_val[5]) begin
        // [RULE14] function set fields
        s_d.bus8 = byte_val[FUNC_DL_BIT];
        s_d.two_lines = byte_val[FUNC_N_BIT];
        s_d.tall_font = byte_val[FUNC_F_BIT];
        s_d.font_tbl = byte_val[FUNC_FT_LSB +: 2];
      end else if (byte_val[4]) begin
        if (byte_val[1:0] == 2'b11) begin
          // [RULE13] mode and power
          s_d.graphic = byte_val[MODE_GC_BIT];
          s_d.power_on = byte_val[MODE_PWR_BIT];
        end else if (byte_val[1:0] == 2'b00) begin
          // [RULE12] cursor or display shift
          if (byte_val[SHIFT_SC_BIT]) begin
            // [RULE23] shift keeps pointer
            s_d.disp_ofs = byte_val[SHIFT_RL_BIT] ? s_q.disp_ofs - 7'h01 : s_q.disp_ofs + 7'h01;
          end else begin
            // [RULE23] cursor move steps pointer
            s_d.ram_ptr = step_ptr(s_q.ram_ptr, byte_val[SHIFT_RL_BIT], s_q.sel_glyph);
          end
        end
      end else if (byte_val[3]) begin
        // [RULE11] display control bits
        s_d.disp_on = byte_val[DISP_ON_BIT];
        s_d.cursor_on = byte_val[DISP_CURSOR_BIT];
        s_d.blink_on = byte_val[DISP_BLINK_BIT];
      end else if (byte_val[2]) begin
        // [RULE10] entry mode bits
        s_d.step_up = byte_val[ENTRY_DIR_BIT];
        s_d.shift_entry = byte_val[ENTRY_SHIFT_BIT];
      end else if (byte_val[1]) begin
        // [RULE8] return home
        s_d.ram_ptr = '0;
        s_d.sel_glyph = 1'b0;
        s_d.disp_ofs = '0;
      end else if (byte_val[0]) begin
        // [RULE7] clear display
        s_d.phase = CDHCP_CLEAR;
        s_d.busy_cnt = BUSY_W'(CLEAR_CYC);
        s_d.clr_idx = '0;
        s_d.ram_ptr = '0;
        s_d.sel_glyph = 1'b0;
        s_d.disp_ofs = '0;
        // [RULE22] force increment
        s_d.step_up = 1'b1;
      end else begin
        // An all-zero command does nothing and needs no busy time.
        s_d.busy = 1'b0;
        s_d.phase = CDHCP_IDLE;
      end
    end
  end

  // ----------
  // Registers
  // ----------
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.phase <= CDHCP_IDLE;
      s_q.step_up <= RST_STEP_UP;
      s_q.bus8 <= RST_BUS8;
    end else begin
      s_q <= s_d;
    end
  end

  // RAM contents are not reset; software clears the display after power-up.
  always_ff @(posedge ref_clk_i) begin
    if (dram_we) begin
      display_ram[dram_wa] <= dram_wd;
    end
    if (gram_we) begin
      glyph_ram[gram_wa] <= dram_wd;
    end
  end

  // [RULE1] only two host registers reachable
  assign db_o = s_q.db_out;
  assign db_oe_o = s_q.db_oe;
  assign busy_o = s_q.busy;
  assign ram_pointer_o = s_q.ram_ptr;
  assign display_on_o = s_q.disp_on;
  assign cursor_on_o = s_q.cursor_on;
  assign blink_on_o = s_q.blink_on;
  assign graphic_mode_o = s_q.graphic;
  assign power_on_o = s_q.power_on;
  assign bus_width_8_o = s_q.bus8;
  assign two_lines_o = s_q.two_lines;
  assign tall_font_o = s_q.tall_font;
  assign font_table_o = s_q.font_tbl;
  assign display_shift_o = s_q.disp_ofs;

endmodule

/* File: rtl/cdhcp_pkg.sv */
// Constants shared by the character display host command port.
// Assumes a single 200 MHz clock and host pins that are asynchronous to it.
// Overview of operation
// [RULE1] Host sees only command and data registers.
// [RULE2] While busy, only status read is honoured.
// [RULE3] Busy flag high until next command acceptable.
// [RULE4] Host polls busy or waits execution time.
// [RULE5] Data write auto-steps the RAM pointer.
// [RULE6] Entry shift happens within the data write.
// [RULE7] Clear blanks display RAM, pointer to zero.
// [RULE8] Home zeroes pointer and display shift.
// [RULE9] Host keeps bit 0 low on home.
// [RULE10] Entry mode stores direction and shift enable.
// [RULE11] Display control stores on, cursor, blink.
// [RULE12] Cursor move or display shift, RAM untouched.
// [RULE13] Mode command stores graphic and power bits.
// [RULE14] Function set stores width, lines, font, table.
// [RULE15] Glyph address load selects glyph RAM.
// [RULE16] Display address load selects display RAM.
// [RULE17] Status read returns busy and pointer.
// [RULE18] Data write stores at pointer in RAM.
// [RULE19] Data read returns byte at pointer.
// [RULE20] Pointer step applied after busy clears.
// [RULE21] Direction bit one increments, zero decrements.
// [RULE22] Clear forces increment, keeps shift enable.
// [RULE23] Cursor moves step pointer, shifts do not.
// [RULE24] Strobe latches select, direction and data.
// [RULE25] Four-bit width: two nibbles, high first.
package cdhcp_pkg;

  // ----------
  // Timing
  // ----------
  localparam int CLK_MHZ = 200;
  localparam int OP_TIME_NS = 100;
  localparam int OP_CYC = (OP_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int CLEAR_TIME_US = 6200;
  localparam int CLEAR_CYC_DEF = CLEAR_TIME_US * CLK_MHZ;
  localparam int BUSY_W = 21;

  // ----------
  // Command field positions
  // ----------
  localparam int STATUS_BUSY_BIT = 7;
  localparam int ENTRY_DIR_BIT = 1;
  localparam int ENTRY_SHIFT_BIT = 0;
  localparam int DISP_ON_BIT = 2;
  localparam int DISP_CURSOR_BIT = 1;
  localparam int DISP_BLINK_BIT = 0;
  localparam int SHIFT_SC_BIT = 3;
  localparam int SHIFT_RL_BIT = 2;
  localparam int MODE_GC_BIT = 3;
  localparam int MODE_PWR_BIT = 2;
  localparam int FUNC_DL_BIT = 4;
  localparam int FUNC_N_BIT = 3;
  localparam int FUNC_F_BIT = 2;
  localparam int FUNC_FT_LSB = 0;

  // ----------
  // Reset values and memory sizes
  // ----------
  localparam logic RST_STEP_UP = 1'b1;
  localparam logic RST_BUS8 = 1'b1;
  localparam logic [7:0] BLANK_CODE = 8'h20;
  localparam int DRAM_DEPTH = 128;
  localparam int GRAM_DEPTH = 64;
  localparam int XFIFO_WIDTH = 16;
  localparam int XFIFO_DEPTH = 8;

  typedef enum logic [1:0] {
    CDHCP_IDLE,
    CDHCP_EXEC,
    CDHCP_CLEAR
  } cdhcp_phase_e;

endpackage

/* File: rtl/cdhcp_sync.sv */
// Two-flop synchroniser for a bundle of asynchronous host pins.
// Assumes each bit is used on its own; no bus coherency is promised.
`timescale 1ns/1ps
module cdhcp_sync #(
  parameter int W = 1
) (
  input wire logic ref_clk_i,      // Core clock.
  input wire logic rst_i,          // Synchronous reset, active high.
  input wire logic [W-1:0] async_i, // Raw pin levels.
  output logic [W-1:0] sync_o      // Levels after two flops.
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule

/* File: rtl/cdhcp_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock; full and empty are exact, no bypass path.
`timescale 1ns/1ps
module cdhcp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk_i,          // Core clock.
  input wire logic rst_i,              // Synchronous reset, active high.
  input wire logic in_valid_i,         // Producer offers a word.
  output logic in_ready_o,             // FIFO has room.
  input wire logic [WIDTH-1:0] in_data_i, // Word offered.
  output logic out_valid_o,            // FIFO holds a word.
  input wire logic out_ready_i,        // Consumer takes the word.
  output logic [WIDTH-1:0] out_data_o  // Oldest word.
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
  } cdhcp_fifo_s;

  cdhcp_fifo_s s_q;
  cdhcp_fifo_s s_d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic do_push;
  logic do_pop;

  assign in_ready_o = (s_q.count != (AW + 1)'(DEPTH));
  assign out_valid_o = (s_q.count != '0);
  assign out_data_o = mem[s_q.rd_ptr];
  assign do_push = in_valid_i && in_ready_o;
  assign do_pop = out_valid_o && out_ready_i;

  always_comb begin
    s_d = s_q;
    if (do_push) begin
      s_d.wr_ptr = (s_q.wr_ptr == AW'(DEPTH - 1)) ? '0 : s_q.wr_ptr + 1'b1;
    end
    if (do_pop) begin
      s_d.rd_ptr = (s_q.rd_ptr == AW'(DEPTH - 1)) ? '0 : s_q.rd_ptr + 1'b1;
    end
    if (do_push && !do_pop) begin
      s_d.count = s_q.count + 1'b1;
    end else if (do_pop && !do_push) begin
      s_d.count = s_q.count - 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (do_push) begin
      mem[s_q.wr_ptr] <= in_data_i;
    end
  end

endmodule

/* File: bench/cdhcp_properties.sv */
// Concurrent checks on the pins of the host command port.
// Assumes one clock domain and sight of the top module's ports only.
`timescale 1ns/1ps
module cdhcp_properties
  import cdhcp_pkg::*;
#(
  parameter int unsigned CLEAR_CYC = CLEAR_CYC_DEF
) (
  input logic ref_clk_i, // Clock.
  input logic rst_i, // Reset.
  input logic bus_8080_i, // Strobe style.
  input logic enable_or_read_strobe_i, // Strobe a.
  input logic direction_or_write_strobe_i, // Strobe b.
  input logic [7:0] db_o, // Read data.
  input logic db_oe_o, // Pin drive.
  input logic busy_o, // Busy.
  input logic [6:0] ram_pointer_o, // Pointer.
  input logic bus_width_8_o, // Width.
  input logic wr_valid_o, // Stream valid.
  input logic [XFIFO_WIDTH-1:0] wr_data_o, // Stream word.
  input logic wr_ready_i // Stream ready.
);
  // ----------
  // Helper counters
  // ----------
  typedef struct packed {logic [11:0] len; logic [11:0] run; logic [3:0] age;} cdhcp_chk_s;
  cdhcp_chk_s st_q;
  cdhcp_chk_s st_d;
  logic active;
  assign active = bus_8080_i ? !(enable_or_read_strobe_i && direction_or_write_strobe_i) : enable_or_read_strobe_i;
  // A full buffer may stretch busy, so stalled cycles stay out of run.
  always_comb begin
    st_d = st_q;
    st_d.len = busy_o ? st_q.len + 12'h001 : 12'h000;
    st_d.run = !busy_o ? 12'h000 : (wr_valid_o && !wr_ready_i) ? st_q.run : st_q.run + 12'h001;
    st_d.age = active ? 4'h0 : (st_q.age == 4'hf) ? st_q.age : st_q.age + 4'h1;
  end
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      st_q <= {12'h000, 12'h000, 4'hf};
    end else begin
      st_q <= st_d;
    end
  end
  // ----------
  // Properties
  // ----------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  a_busy_stands: assert property ($rose(busy_o) |=> busy_o [*8]) else $error("busy fell early");
  a_busy_min_len: assert property ($fell(busy_o) |-> st_q.len >= OP_CYC) else $error("busy too short");
  a_clear_bound: assert property ($fell(busy_o) |-> st_q.run <= CLEAR_CYC + 1) else $error("busy too long");
  a_busy_cause: assert property ($rose(busy_o) |-> st_q.age <= 4'h8) else $error("busy without strobe");
  a_oe_idle: assert property ((bus_8080_i == enable_or_read_strobe_i) [*5] |-> !db_oe_o)
    else $error("pins driven while idle");
  a_oe_read: assert property ((bus_8080_i && !enable_or_read_strobe_i) [*5] |-> db_oe_o)
    else $error("pins not driven on read");
  a_ptr_steady: assert property (busy_o && $past(busy_o) |-> $stable(ram_pointer_o))
    else $error("pointer moved while busy");
  a_stream_hold: assert property (wr_valid_o && !wr_ready_i |=> wr_valid_o && $stable(wr_data_o))
    else $error("stream word dropped");
  a_reset_state: assert property ($fell(rst_i) |-> bus_width_8_o && !busy_o && ram_pointer_o == 7'h00)
    else $error("bad state after reset");
  a_nibble_low: assert property (!bus_width_8_o && db_oe_o |-> db_o[3:0] == 4'h0)
    else $error("low nibble not zero");
  c_clear: cover property ($fell(busy_o) && st_q.len > 12'h080);
  c_stall: cover property (busy_o && wr_valid_o && !wr_ready_i);
  c_nibble: cover property (!bus_width_8_o && db_oe_o);
endmodule

bind cdhcp_top cdhcp_properties #(.CLEAR_CYC(CLEAR_CYC)) cdhcp_properties_inst (.ref_clk_i, .rst_i, .bus_8080_i,
  .enable_or_read_strobe_i, .direction_or_write_strobe_i, .db_o, .db_oe_o, .busy_o, .ram_pointer_o,
  .bus_width_8_o, .wr_valid_o, .wr_data_o, .wr_ready_i);

/* File: bench/cdhcp_host_model.sv */
// Behavioural host on the parallel pins of the port.
// Assumes its tasks are called one at a time.
`timescale 1ns/1ps
module cdhcp_host_model (
  input logic ref_clk_i, // Clock.
  input logic mode_8080_i, // 1: separate strobes.
  input logic [7:0] pins_i, // Data from the port.
  output logic rs_o, // Register select.
  output logic strb_a_o, // Enable or read strobe.
  output logic strb_b_o, // Direction or write strobe.
  output logic [7:0] data_o // Data to the port.
);
  int hold = 6;
  bit nib4 = 1'b0;
  initial begin
    rs_o = 1'b0;
    strb_a_o = 1'b1;
    strb_b_o = 1'b1;
    data_o = 8'h00;
  end
  task automatic idle(input logic m);
    strb_a_o <= m;
    strb_b_o <= 1'b1;
  endtask
  task automatic pin(input logic rs, input logic rd, input logic [7:0] wd, output logic [7:0] q);
    @(posedge ref_clk_i);
    rs_o <= rs;
    data_o <= wd;
    if (mode_8080_i) begin
      strb_a_o <= !rd;
      strb_b_o <= rd;
    end else begin
      strb_b_o <= rd;
      @(posedge ref_clk_i);
      strb_a_o <= 1'b1;
    end
    repeat (hold) @(posedge ref_clk_i);
    q = pins_i;
    strb_a_o <= mode_8080_i;
    if (mode_8080_i) strb_b_o <= 1'b1;
    repeat (hold) @(posedge ref_clk_i);
    // Released lines flip, so a late sample cannot pass.
    data_o <= ~wd;
  endtask
  task automatic put(input logic rs, input logic rd, input logic [7:0] wd, output logic [7:0] q);
    logic [7:0] hi;
    logic [7:0] lo;
    if (nib4) begin
      pin(rs, rd, wd, hi);
      pin(rs, rd, {wd[3:0], 4'h0}, lo);
      q = {hi[7:4], lo[7:4]};
    end else begin
      pin(rs, rd, wd, q);
    end
  endtask
  task automatic poll(output bit ok);
    logic [7:0] s;
    ok = 1'b0;
    for (int i = 0; i < 100 && !ok; i++) begin
      put(1'b0, 1'b1, 8'h00, s);
      ok = (s[7] === 1'b0);
    end
  endtask
endmodule

/* File: bench/testbench.sv */
// Self-checking bench for the host command port.
// Assumes the package constants and a short clear time.
`timescale 1ns/1ps
module testbench;
  import cdhcp_pkg::*;
  localparam int unsigned CLR = 200;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic bus_8080_i = 1'b1;
  logic wr_ready_i = 1'b1;
  logic rs, sa, sb, db_oe_o, busy_o, display_on_o, cursor_on_o, blink_on_o, graphic_mode_o, power_on_o;
  logic bus_width_8_o, two_lines_o, tall_font_o, wr_valid_o;
  logic [1:0] font_table_o;
  logic [7:0] dbi, db_o, q;
  logic [6:0] ram_pointer_o, display_shift_o;
  logic [15:0] wr_data_o;
  logic [15:0] seen_q[$];
  logic [15:0] exp_q[$];
  logic [17:0] ctl [6] = '{{8'h3f, 10'h3e0}, {8'h0f, 10'h3fc}, {8'h1f, 10'h3ff}, {8'h33, 10'h27f},
                          {8'h0a, 10'h26b}, {8'h17, 10'h269}};
  logic [21:0] mv [4] = '{{8'h14, 14'h0088}, {8'h10, 14'h0087}, {8'h18, 14'h0107}, {8'h1c, 14'h0087}};
  int err_total = 0;
  int checks = 0;
  bit ok;

  always #2.5 ref_clk_i = ~ref_clk_i;

  cdhcp_top #(.CLEAR_CYC(CLR)) cdhcp_top_inst (.ref_clk_i, .rst_i, .bus_8080_i, .register_select_i(rs),
    .enable_or_read_strobe_i(sa), .direction_or_write_strobe_i(sb), .db_i(dbi), .db_o, .db_oe_o, .busy_o,
    .ram_pointer_o, .display_on_o, .cursor_on_o, .blink_on_o, .graphic_mode_o, .power_on_o, .bus_width_8_o,
    .two_lines_o, .tall_font_o, .font_table_o, .display_shift_o, .wr_valid_o, .wr_data_o, .wr_ready_i);
  cdhcp_host_model host (.ref_clk_i, .mode_8080_i(bus_8080_i), .pins_i(db_o), .rs_o(rs), .strb_a_o(sa),
    .strb_b_o(sb), .data_o(dbi));

  always @(posedge ref_clk_i) if (wr_valid_o === 1'b1 && wr_ready_i) seen_q.push_back(wr_data_o);

  // ----------
  // Tasks
  // ----------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic settle();
    host.poll(ok);
    if (!ok) begin
      check(8'h80, 8'h00);
      conclude();
    end
  endtask
  task automatic cmd(input logic [7:0] b);
    host.put(1'b0, 1'b0, b, q);
    settle();
  endtask
  task automatic wr(input logic [7:0] b, input logic [7:0] where);
    host.put(1'b1, 1'b0, b, q);
    exp_q.push_back({where, b});
    settle();
  endtask
  task automatic rdd();
    host.put(1'b1, 1'b1, 8'h00, q);
    settle();
  endtask
  task automatic stat();
    host.put(1'b0, 1'b1, 8'h00, q);
  endtask
  task automatic stream_check();
    check(16'(seen_q.size()), 16'(exp_q.size()));
    while (exp_q.size() > 0 && seen_q.size() > 0) check(seen_q.pop_front(), exp_q.pop_front());
    exp_q.delete();
  endtask
  task automatic done(input string n);
    $display("test %s finished, err_total=%0d", n, err_total);
  endtask

  initial begin
    repeat (90000) @(posedge ref_clk_i);
    check(8'h01, 8'h00);
    conclude();
  end

  // ----------
  // Scenarios
  // ----------
  initial begin
    repeat (20) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    check({busy_o, bus_width_8_o, ram_pointer_o}, 9'h080);
    done("reset");
    foreach (ctl[i]) begin
      cmd(ctl[i][17:10]);
      check({bus_width_8_o, two_lines_o, tall_font_o, font_table_o, display_on_o, cursor_on_o, blink_on_o,
             graphic_mode_o, power_on_o}, ctl[i][9:0]);
    end
    done("controls");
    seen_q.delete();
    cmd(8'h85);
    check(ram_pointer_o, 8'h05);
    cmd(8'h06);
    host.put(1'b1, 1'b0, 8'h41, q);
    exp_q.push_back(16'h0541);
    stat();
    check(q, 8'h85);
    settle();
    wr(8'h42, 8'h06);
    stat();
    check(q, 8'h07);
    cmd(8'h04);
    wr(8'h43, 8'h07);
    check(ram_pointer_o, 8'h06);
    cmd(8'h07);
    wr(8'h44, 8'h06);
    check({display_shift_o, ram_pointer_o}, 16'h0087);
    foreach (mv[i]) begin
      cmd(mv[i][21:14]);
      check({display_shift_o, ram_pointer_o}, mv[i][13:0]);
    end
    cmd(8'h85);
    rdd();
    check(q, 8'h41);
    check(ram_pointer_o, 8'h06);
    stream_check();
    done("display data");
    cmd(8'h43);
    check(ram_pointer_o, 8'h03);
    wr(8'h1f, 8'h83);
    cmd(8'h43);
    rdd();
    check(q, 8'h1f);
    stream_check();
    // home sent with bit 0 low
    cmd(8'h02);
    check({display_shift_o, ram_pointer_o}, 16'h0000);
    done("glyph and home");
    host.put(1'b0, 1'b0, 8'h0c, q);
    host.put(1'b0, 1'b0, 8'h08, q);
    settle();
    check({display_on_o, cursor_on_o}, 8'h02);
    done("refused");
    cmd(8'h05);
    cmd(8'h18);
    cmd(8'h85);
    cmd(8'h01);
    check({display_shift_o, ram_pointer_o}, 16'h0000);
    seen_q.delete();
    wr(8'h50, 8'h00);
    check({display_shift_o, ram_pointer_o}, 16'h0081);
    cmd(8'h85);
    rdd();
    check(q, BLANK_CODE);
    stream_check();
    done("clear");
    cmd(8'h06);
    cmd(8'h80);
    seen_q.delete();
    wr_ready_i <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      host.put(1'b1, 1'b0, 8'h60 + 8'(i), q);
      exp_q.push_back({1'b0, 7'(i), 8'h60 + 8'(i)});
      repeat (40) @(posedge ref_clk_i);
    end
    check(busy_o, 1'b1);
    wr_ready_i <= 1'b1;
    settle();
    stream_check();
    check(ram_pointer_o, 8'h09);
    done("buffer");
    host.put(1'b0, 1'b0, 8'h28, q);
    host.nib4 = 1'b1;
    settle();
    check({bus_width_8_o, two_lines_o}, 8'h01);
    cmd(8'h8a);
    stat();
    check(q, 8'h0a);
    cmd(8'h30);
    host.nib4 = 1'b0;
    check(bus_width_8_o, 1'b1);
    done("nibbles");
    @(posedge ref_clk_i);
    bus_8080_i <= 1'b0;
    host.idle(1'b0);
    rst_i <= 1'b1;
    repeat (20) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    check({display_on_o, ram_pointer_o}, 8'h00);
    host.hold = 10;
    seen_q.delete();
    cmd(8'h0d);
    check({display_on_o, cursor_on_o, blink_on_o}, 8'h05);
    cmd(8'h9b);
    wr(8'h5a, 8'h1b);
    cmd(8'h9b);
    rdd();
    check(q, 8'h5a);
    stat();
    check(q, 8'h1c);
    stream_check();
    done("enable strobe");
    conclude();
  end
endmodule
